// File: pilu_pkg.sv
`default_nettype none
package pilu_pkg;
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b01,
      ST_ACCEPT = 2'b10
   } pilu_state_t;

   // Byte lanes: lane 0 holds bits 7:0 of the 32-bit latch/enable words
   localparam logic [3:0][7:0] PEND_ADDR = {8'h3D, 8'h3C, 8'h2F, 8'h2E};
   localparam logic [3:0][7:0] EN_ADDR   = {8'h2D, 8'h2C, 8'h3B, 8'h3A};
   localparam int              LANES     = 4;

   localparam int MASTER_BIT  = 0;
   localparam int SRC_SOFT    = 1;
   localparam int SRC_TRAP    = 2;
   localparam int SRC_WDT     = 3;
   localparam int SRC_EXT0    = 4;
   localparam int PSW_MASTER_BIT = 0;

   localparam logic [31:0] LATCH_IMPL  = 32'hFFFF_FFFC;
   localparam logic [31:0] EN_IMPL     = 32'h3FF0_2FF1;
   localparam logic [31:0] LATCH_RESET = 32'h0000_0000;
   localparam logic [31:0] EN_RESET    = 32'h0000_0000;

   localparam logic [15:0] VEC_BASE_LO = 16'hFFFE;
   localparam logic [15:0] VEC_BASE_HI = 16'hFFDE;
   localparam logic [4:0]  HI_FIRST    = 5'h10;

   // One machine cycle is four core clocks
   localparam int          MC_CLKS      = 4;
   localparam int          ACCEPT_MC    = 8;
   localparam int          ACCEPT_CLKS  = MC_CLKS * ACCEPT_MC;
   localparam logic [5:0]  ACC_LAST     = 6'(ACCEPT_CLKS - 1);
   localparam logic [5:0]  PUSH_PSW_CNT = 6'(MC_CLKS * 1);
   localparam logic [5:0]  PUSH_PCH_CNT = 6'(MC_CLKS * 2);
   localparam logic [5:0]  PUSH_PCL_CNT = 6'(MC_CLKS * 3);
   localparam logic [15:0] SP_STEP      = 16'h0001;
   localparam logic [15:0] SP_PUSHES    = 16'h0003;
endpackage
`default_nettype wire

// File: pilu_prio_enc.sv
`default_nettype none
module pilu_prio_enc (
   input  wire logic [31:0] elig,
   output logic             found,
   output logic [4:0]       idx,
   output logic [15:0]      vec
);
   logic [32:0] lower;
   logic [31:0] onehot;

   assign lower[0] = 1'b0;
   // Lowest index wins
   genvar g;
   for (g = 0; g < 32; g++) begin : g_rank
      assign onehot[g]  = elig[g] & ~lower[g];
      assign lower[g+1] = lower[g] | elig[g];
   end

   always_comb begin
      found = lower[32];
      idx   = 5'h00;
      for (int i = 0; i < 32; i++) begin
         if (onehot[i]) begin
            idx = idx | 5'(i);
         end
      end
      // Vectors step down by two; upper bank restarts lower in the table
      if (idx < pilu_pkg::HI_FIRST) begin
         vec = 16'(pilu_pkg::VEC_BASE_LO - {10'h000, idx, 1'b0});
      end else begin
         vec = 16'(pilu_pkg::VEC_BASE_HI - {10'h000, idx, 1'b0});
      end
   end
endmodule
`default_nettype wire

// File: pilu_core.sv
`default_nettype none
module pilu_core (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [7:0]  sfr_wdata,
   output logic [7:0]       sfr_rdata,
   input  wire logic [31:4] maskable_event,
   input  wire logic        trap_event,
   input  wire logic        wdt_event,
   input  wire logic        soft_irq,
   input  wire logic        bad_opcode_irq,
   input  wire logic        ext0_pin_enable,
   input  wire logic        trap_action_select,
   input  wire logic        wdt_action_select,
   input  wire logic        cpu_boundary,
   input  wire logic [15:0] cpu_pc,
   input  wire logic [15:0] cpu_sp,
   input  wire logic [7:0]  cpu_psw,
   input  wire logic        return_from_irq,
   input  wire logic [7:0]  pop_psw,
   output logic             irq_req,
   output logic [15:0]      irq_vector,
   output logic             irq_busy,
   output logic             stack_we,
   output logic [15:0]      stack_addr,
   output logic [7:0]       stack_data,
   output logic             pc_load,
   output logic [15:0]      pc_value,
   output logic             sp_load,
   output logic [15:0]      sp_value
);
   typedef struct packed {
      pilu_pkg::pilu_state_t st;
      logic [31:0]           latch;
      logic [31:0]           en;
      logic [5:0]            cnt;
      logic [4:0]            win_idx;
      logic [15:0]           win_vec;
      logic [15:0]           pc_save;
      logic [15:0]           sp_save;
      logic [15:0]           sp_new;
      logic [7:0]            psw_save;
      logic [7:0]            rdata;
      logic                  req;
      logic [15:0]           vec;
      logic                  stack_we;
      logic [15:0]           stack_addr;
      logic [7:0]            stack_data;
      logic                  pc_load;
      logic                  sp_load;
      logic                  busy;
   } pilu_regs_t;

   pilu_regs_t s_q;
   pilu_regs_t s_d;

   logic [31:0] set_vec;
   logic [31:0] elig;
   logic [31:0] clr_mask;
   logic [31:0] en_wmask;
   logic [31:0] en_wdata;
   logic [31:0] acc_clr;
   logic [3:0]  pend_hit;
   logic [3:0]  en_hit;
   logic        found;
   logic [4:0]  win_idx;
   logic [15:0] win_vec;
   logic        accept_fire;
   logic        idle;

   assign set_vec = {maskable_event,
                     wdt_event & ~wdt_action_select,
                     trap_event & ~trap_action_select,
                     2'b00};

   genvar g;
   for (g = 0; g < pilu_pkg::LANES; g++) begin : g_lane
      assign pend_hit[g]          = sfr_wr & (sfr_addr == pilu_pkg::PEND_ADDR[g]);
      assign en_hit[g]            = sfr_wr & (sfr_addr == pilu_pkg::EN_ADDR[g]);
      assign clr_mask[g*8 +: 8]   = pend_hit[g] ? ~sfr_wdata : 8'h00;
      assign en_wmask[g*8 +: 8]   = en_hit[g] ? 8'hFF : 8'h00;
      assign en_wdata[g*8 +: 8]   = sfr_wdata;
   end

   assign idle = (s_q.st == pilu_pkg::ST_IDLE);

   // Soft and bad-opcode have no latch
   always_comb begin
      elig = s_q.latch & s_q.en & {32{s_q.en[pilu_pkg::MASTER_BIT]}};
      elig[pilu_pkg::SRC_EXT0] = elig[pilu_pkg::SRC_EXT0] & ext0_pin_enable;
      elig[pilu_pkg::SRC_WDT]  = s_q.latch[pilu_pkg::SRC_WDT];
      elig[pilu_pkg::SRC_TRAP] = s_q.latch[pilu_pkg::SRC_TRAP];
      elig[pilu_pkg::SRC_SOFT] = soft_irq | bad_opcode_irq;
      elig[0]                  = 1'b0;
   end

   pilu_prio_enc u_enc (
      .elig  (elig),
      .found (found),
      .idx   (win_idx),
      .vec   (win_vec)
   );

   assign accept_fire = idle & cpu_boundary & found;

   always_comb begin
      acc_clr = 32'h0000_0000;
      if (accept_fire) begin
         acc_clr[win_idx] = 1'b1;
      end
   end

   always_comb begin
      s_d          = s_q;
      s_d.stack_we = 1'b0;
      s_d.pc_load  = 1'b0;
      s_d.sp_load  = 1'b0;

      s_d.latch = (((s_q.latch & ~clr_mask) & ~acc_clr) | set_vec) & pilu_pkg::LATCH_IMPL;

      s_d.en = ((s_q.en & ~en_wmask) | (en_wdata & en_wmask)) & pilu_pkg::EN_IMPL;

      if (return_from_irq) begin
         s_d.en[pilu_pkg::MASTER_BIT] = pop_psw[pilu_pkg::PSW_MASTER_BIT];
      end

      s_d.rdata = 8'h00;
      if (sfr_rd) begin
         for (int i = 0; i < pilu_pkg::LANES; i++) begin
            if (sfr_addr == pilu_pkg::PEND_ADDR[i]) begin
               s_d.rdata = s_q.latch[i*8 +: 8];
            end
            if (sfr_addr == pilu_pkg::EN_ADDR[i]) begin
               s_d.rdata = s_q.en[i*8 +: 8];
            end
         end
      end

      s_d.req = idle & found;
      s_d.vec = found ? win_vec : s_q.vec;

      unique case (s_q.st)
         pilu_pkg::ST_IDLE: begin
            if (accept_fire) begin
               s_d.st       = pilu_pkg::ST_ACCEPT;
               s_d.cnt      = 6'h00;
               s_d.win_idx  = win_idx;
               s_d.win_vec  = win_vec;
               s_d.pc_save  = cpu_pc;
               s_d.sp_save  = cpu_sp;
               s_d.sp_new   = 16'(cpu_sp - pilu_pkg::SP_PUSHES);
               s_d.psw_save = cpu_psw;
               s_d.psw_save[pilu_pkg::PSW_MASTER_BIT] = s_q.en[pilu_pkg::MASTER_BIT];
               s_d.en[pilu_pkg::MASTER_BIT] = 1'b0;
            end
         end
         pilu_pkg::ST_ACCEPT: begin
            s_d.req = 1'b0;
            s_d.cnt = 6'(s_q.cnt + 6'h01);
            // Push status, PC high, PC low
            if (s_q.cnt == pilu_pkg::PUSH_PSW_CNT) begin
               s_d.stack_we   = 1'b1;
               s_d.stack_addr = s_q.sp_save;
               s_d.stack_data = s_q.psw_save;
            end
            if (s_q.cnt == pilu_pkg::PUSH_PCH_CNT) begin
               s_d.stack_we   = 1'b1;
               s_d.stack_addr = 16'(s_q.sp_save - pilu_pkg::SP_STEP);
               s_d.stack_data = s_q.pc_save[15:8];
            end
            if (s_q.cnt == pilu_pkg::PUSH_PCL_CNT) begin
               s_d.stack_we   = 1'b1;
               s_d.stack_addr = 16'(s_q.sp_save - pilu_pkg::SP_STEP - pilu_pkg::SP_STEP);
               s_d.stack_data = s_q.pc_save[7:0];
            end
            if (s_q.cnt == pilu_pkg::ACC_LAST) begin
               s_d.st      = pilu_pkg::ST_IDLE;
               s_d.pc_load = 1'b1;
               s_d.sp_load = 1'b1;
            end
         end
      endcase
      // Busy kept in its own flop so the output needs no state decode
      s_d.busy = (s_d.st == pilu_pkg::ST_ACCEPT);
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q       <= '0;
         s_q.st    <= pilu_pkg::ST_IDLE;
         s_q.latch <= pilu_pkg::LATCH_RESET;
         s_q.en    <= pilu_pkg::EN_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Vector and stack pointer are held after pc_load so the CPU may sample late
   assign sfr_rdata  = s_q.rdata;
   assign irq_req    = s_q.req;
   assign irq_vector = s_q.vec;
   assign irq_busy   = s_q.busy;
   assign stack_we   = s_q.stack_we;
   assign stack_addr = s_q.stack_addr;
   assign stack_data = s_q.stack_data;
   assign pc_load    = s_q.pc_load;
   assign pc_value   = s_q.win_vec;
   assign sp_load    = s_q.sp_load;
   assign sp_value   = s_q.sp_new;

   localparam int ACC_DLY  = pilu_pkg::ACCEPT_CLKS + 1;
   localparam int PSW_DLY  = 6;
   localparam int PUSH_GAP = 4;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   sequence push_psw_s;
      ##PSW_DLY (stack_we && (stack_addr == $past(cpu_sp, 6)));
   endsequence
   sequence push_pc_s;
      ##PUSH_GAP (stack_we && (stack_addr == 16'($past(stack_addr, 4) - 16'h0001)))
      ##PUSH_GAP (stack_we && (stack_addr == 16'($past(stack_addr, 4) - 16'h0001)));
   endsequence

   accept_time_a: assert property (accept_fire |-> ##ACC_DLY (pc_load && sp_load))
      else $error("acceptance did not end after eight machine cycles");
   push_order_a: assert property (accept_fire |-> push_psw_s ##0 push_pc_s)
      else $error("stack pushes out of order or misplaced");
   sp_minus_a: assert property (sp_load |-> (sp_value == 16'($past(stack_addr, 20) - 16'h0002)))
      else $error("stack pointer not decremented by three");
   master_clear_a: assert property (accept_fire |=> !s_q.en[pilu_pkg::MASTER_BIT] && irq_busy)
      else $error("master enable not cleared on acceptance");
   latch_clear_a: assert property ((accept_fire && !set_vec[win_idx]) |=>
      !s_q.latch[$past(win_idx)])
      else $error("accepted latch still set");
   no_sw_set_a: assert property ((s_q.latch & ~$past(s_q.latch) & ~$past(set_vec)) == 32'h0)
      else $error("latch set without a request");
   set_wins_a: assert property ((set_vec != 32'h0) |=>
      ((s_q.latch & $past(set_vec & pilu_pkg::LATCH_IMPL)) == $past(set_vec & pilu_pkg::LATCH_IMPL)))
      else $error("request lost against a clear");
   nmi_pass_a: assert property ((idle && cpu_boundary && (s_q.latch[3:2] != 2'b00)) |=> irq_busy)
      else $error("non-maskable request not accepted");
   mask_gate_a: assert property ((idle && cpu_boundary && !s_q.en[pilu_pkg::MASTER_BIT] &&
      (s_q.latch[3:2] == 2'b00) && !soft_irq && !bad_opcode_irq) |=> !irq_busy)
      else $error("maskable accepted while master enable clear");
   pend_read_a: assert property ((sfr_rd && (sfr_addr == pilu_pkg::PEND_ADDR[0])) |=>
      (sfr_rdata == $past(s_q.latch[7:0])))
      else $error("pending read does not show latches");
endmodule
`default_nettype wire

// File: pilu_cpu_model.sv
`default_nettype none
module pilu_cpu_model (
   input  wire logic        core_clk,
   input  wire logic        run,
   input  wire logic        slow,
   input  wire logic        irq_busy,
   input  wire logic        pc_load,
   input  wire logic [15:0] pc_value,
   input  wire logic        sp_load,
   input  wire logic [15:0] sp_value,
   input  wire logic        stack_we,
   input  wire logic [15:0] stack_addr,
   input  wire logic [7:0]  stack_data,
   output logic             cpu_boundary,
   output logic [15:0]      cpu_pc,
   output logic [15:0]      cpu_sp,
   output logic [7:0]       cpu_psw
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:255];
   logic [1:0] ph;
   int         cnt;
   int         blen;
   initial begin
      cpu_boundary = 1'b0;
      cpu_pc = 16'h1234;
      cpu_sp = 16'h00F0;
      cpu_psw = 8'hA4;
      ph = 2'h0;
      cnt = 0;
      blen = 0;
      forever begin
         @(posedge core_clk);
         #1;
         ph = ph + 2'h1;
         // Slow mode gives a boundary only one cycle in four
         cpu_boundary = run && !irq_busy && (!slow || ph == 2'h0);
         if (irq_busy) cnt++;
         if (stack_we) mem[stack_addr[7:0]] = stack_data;
         if (sp_load) cpu_sp = sp_value;
         if (pc_load) begin
            cpu_pc = pc_value;
            blen = cnt;
            cnt = 0;
         end
      end
   end
endmodule
`default_nettype wire

// File: pilu_core_tb.sv
`default_nettype none
module pilu_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk, arst_n, sfr_wr, sfr_rd, trap_event, wdt_event, soft_irq;
   logic        bad_opcode_irq, ext0_pin_enable, trap_action_select, wdt_action_select;
   logic        cpu_boundary, return_from_irq, irq_req, irq_busy, stack_we, pc_load;
   logic        sp_load, run, slow;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, cpu_psw, pop_psw, stack_data, en_lo;
   logic [15:0] cpu_pc, cpu_sp, irq_vector, stack_addr, pc_value, sp_value;
   logic [31:4] maskable_event;
   int          err_total, checks_done;

   pilu_core dut (.core_clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
      .maskable_event, .trap_event, .wdt_event, .soft_irq, .bad_opcode_irq, .ext0_pin_enable,
      .trap_action_select, .wdt_action_select, .cpu_boundary, .cpu_pc, .cpu_sp, .cpu_psw,
      .return_from_irq, .pop_psw, .irq_req, .irq_vector, .irq_busy, .stack_we, .stack_addr,
      .stack_data, .pc_load, .pc_value, .sp_load, .sp_value);
   pilu_cpu_model cpu (.core_clk, .run, .slow, .irq_busy, .pc_load, .pc_value, .sp_load,
      .sp_value, .stack_we, .stack_addr, .stack_data, .cpu_boundary, .cpu_pc, .cpu_sp,
      .cpu_psw);

   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      if (a == 8'h3A) en_lo = d & pilu_pkg::EN_IMPL[7:0];
      @(posedge core_clk);
      #1;
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      #1;
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge core_clk);
      #1;
      sfr_rd = 1'b0;
      chk({8'h00, sfr_rdata}, {8'h00, e});
   endtask
   task automatic ev(input int i);
      @(posedge core_clk);
      #1;
      if (i == 2) trap_event = 1'b1;
      else if (i == 3) wdt_event = 1'b1;
      else maskable_event[i] = 1'b1;
      @(posedge core_clk);
      #1;
      trap_event = 1'b0;
      wdt_event = 1'b0;
      maskable_event = '0;
   endtask
   function automatic logic [15:0] vec(input int i);
      return (i < 16) ? 16'hFFFE - 16'(2 * i) : 16'hFFDE - 16'(2 * i);
   endfunction
   // Waits out one acceptance, checks it, then returns with the saved status
   task automatic acc(input logic [15:0] v);
      logic [15:0] sp0;
      logic [15:0] pc0;
      int          n;
      n = 0;
      while (irq_busy !== 1'b1 && n < 200) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk({15'h0000, irq_busy}, 16'h0001);
      soft_irq = 1'b0;
      bad_opcode_irq = 1'b0;
      sp0 = cpu_sp;
      pc0 = cpu_pc;
      chk({8'h00, cpu.mem[sp0[7:0]]}, 16'h0000);
      n = 0;
      while (pc_load !== 1'b1 && n < 200) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk({15'h0000, pc_load}, 16'h0001);
      // The model loads its PC and cycle count in this very time step
      #1;
      chk(16'(cpu.blen), 16'(pilu_pkg::ACCEPT_CLKS));
      chk(pc_value, v);
      chk(sp_value, sp0 - 16'h0003);
      chk({8'h00, cpu.mem[sp0[7:0]]}, {8'h00, cpu_psw[7:1], en_lo[0]});
      chk({cpu.mem[8'(sp0 - 16'h1)], cpu.mem[8'(sp0 - 16'h2)]}, pc0);
      rd(8'h3A, en_lo & 8'hFE);
      @(posedge core_clk);
      #1;
      return_from_irq = 1'b1;
      pop_psw = {7'h00, en_lo[0]};
      @(posedge core_clk);
      #1;
      return_from_irq = 1'b0;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      err_total++;
      test_done();
   end
   initial begin
      {arst_n, sfr_wr, sfr_rd, trap_event, wdt_event, soft_irq, bad_opcode_irq} = '0;
      {ext0_pin_enable, return_from_irq, run, slow, sfr_addr, sfr_wdata} = '0;
      {pop_psw, en_lo, maskable_event} = '0;
      {trap_action_select, wdt_action_select} = 2'b11;
      {err_total, checks_done} = '0;
      for (int k = 0; k < 256; k++) cpu.mem[k] = 8'h00;
      repeat (12) @(posedge core_clk);
      #1;
      arst_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(pilu_pkg::PEND_ADDR[i], 8'h00);
         rd(pilu_pkg::EN_ADDR[i], 8'h00);
         wr(pilu_pkg::EN_ADDR[i], 8'hFF);
         rd(pilu_pkg::EN_ADDR[i], pilu_pkg::EN_IMPL[i*8+:8]);
      end
      rd(8'h30, 8'h00);
      wr(8'h3A, 8'hF0);
      ev(2);
      ev(3);
      rd(8'h2E, 8'h00);
      {trap_action_select, wdt_action_select} = 2'b00;
      ev(2);
      ev(3);
      ev(4);
      ev(6);
      ev(7);
      rd(8'h2E, 8'hDC);
      wr(8'h2E, 8'hBF);
      rd(8'h2E, 8'h9C);
      wr(8'h2E, 8'hFF);
      wr(8'h3D, 8'hFF);
      rd(8'h2E, 8'h9C);
      rd(8'h3D, 8'h00);
      wr(8'h2E, 8'h0C);
      rd(8'h2E, 8'h0C);
      fork
         ev(8);
         wr(8'h2F, 8'h00);
      join
      rd(8'h2F, 8'h01);
      wr(8'h2F, 8'h00);
      soft_irq = 1'b1;
      rd(8'h2E, 8'h0C);
      run = 1'b1;
      acc(16'hFFFC);
      acc(16'hFFFA);
      acc(16'hFFF8);
      bad_opcode_irq = 1'b1;
      acc(16'hFFFC);
      ev(4);
      ev(5);
      repeat (10) @(posedge core_clk);
      chk({15'h0000, irq_req}, 16'h0000);
      rd(8'h2E, 8'h30);
      wr(8'h3A, 8'hF1);
      acc(16'hFFF4);
      rd(8'h2E, 8'h10);
      ext0_pin_enable = 1'b1;
      acc(16'hFFF6);
      for (int i = 5; i < 32; i++) begin
         if (pilu_pkg::EN_IMPL[i]) begin
            ev(i);
            acc(vec(i));
         end
      end
      run = 1'b0;
      slow = 1'b1;
      ev(20);
      ev(9);
      ev(5);
      ev(2);
      rd(8'h3C, 8'h10);
      chk({15'h0000, irq_req}, 16'h0001);
      chk(irq_vector, 16'hFFFA);
      run = 1'b1;
      acc(16'hFFFA);
      acc(16'hFFF4);
      acc(16'hFFEC);
      acc(16'hFFB6);
      for (int i = 0; i < 4; i++) rd(pilu_pkg::PEND_ADDR[i], 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
